// file: nvm_seq_pkg.sv
// constants shared by the test-port configuration-memory access sequencer
package nvm_seq_pkg;
	// apb register byte offsets
	localparam logic [7:0] ctrl_offset       = 8'h00;
	localparam logic [7:0] status_offset     = 8'h04;
	localparam logic [7:0] fuse_offset       = 8'h08;
	localparam logic [7:0] ident_base_offset = 8'h10;
	localparam logic [7:0] ident_last_offset = 8'h1C;

	// reset values
	localparam logic [7:0] fuse_low_reset  = 8'hFF;
	localparam logic [7:0] fuse_high_reset = 8'hBF;
	localparam logic [7:0] lock_reset      = 8'hFF;

	// field positions
	localparam int port_enable_fuse_bit = 6;
	localparam int disable_ctrl_bit     = 0;

	// test port widths and codes
	localparam int         ir_width     = 4;
	localparam logic [3:0] ir_capture   = 4'h1;
	localparam logic [3:0] prog_ir_code = 4'h5;
	localparam logic [3:0] bypass_code  = 4'hF;
	localparam int         dr_width     = 24;
	localparam int         ident_depth  = 4;
	localparam int         ident_aw     = 2;

	// programming commands, carried in dr[23:16]; data in dr[7:0]
	localparam logic [7:0] cmd_lock_wr_en  = 8'h7A;
	localparam logic [7:0] cmd_lock_load   = 8'h7B;
	localparam logic [7:0] cmd_lock_commit = 8'h7C;
	localparam logic [7:0] cmd_lock_poll   = 8'h7D;
	localparam logic [7:0] cmd_cfg_rd_en   = 8'h8A;
	localparam logic [7:0] cmd_fuse_high   = 8'h8B;
	localparam logic [7:0] cmd_fuse_low    = 8'h8C;
	localparam logic [7:0] cmd_lock_rd     = 8'h8D;
	localparam logic [7:0] cmd_all_rd      = 8'h8E;
	localparam logic [7:0] cmd_sig_en      = 8'h9A;
	localparam logic [7:0] cmd_sig_addr    = 8'h9B;
	localparam logic [7:0] cmd_sig_rd      = 8'h9C;
	localparam logic [7:0] cmd_cal_en      = 8'hAA;
	localparam logic [7:0] cmd_cal_addr    = 8'hAB;
	localparam logic [7:0] cmd_cal_rd      = 8'hAC;
	localparam logic [1:0] cal_index       = 2'h3;

	// timing
	localparam int clk_period_ps            = 25000;
	localparam int write_completion_time_ns = 4500000;
	localparam int write_completion_cycles  = (write_completion_time_ns / clk_period_ps) * 1000;

	typedef enum logic [3:0] {
		tap_reset, tap_idle, tap_sel_dr, tap_cap_dr, tap_shift_dr, tap_exit1_dr,
		tap_pause_dr, tap_exit2_dr, tap_upd_dr, tap_sel_ir, tap_cap_ir,
		tap_shift_ir, tap_exit1_ir, tap_pause_ir, tap_exit2_ir, tap_upd_ir
	} tap_state_type;

	typedef enum logic [2:0] {
		mode_none, mode_lock_wr, mode_cfg_rd, mode_sig_rd, mode_cal_rd
	} mode_type;
endpackage : nvm_seq_pkg

// file: ident_mem.sv
// small identity store: three signature bytes and the calibration byte
`timescale 1ns/1ps
module ident_mem
	import nvm_seq_pkg::*;
(
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                wr_en,
	input  wire logic [ident_aw-1:0] wr_addr,
	input  wire logic [7:0]          wr_data,
	input  wire logic [ident_aw-1:0] rd_addr_a,
	output logic      [7:0]          rd_data_a,
	input  wire logic [ident_aw-1:0] rd_addr_b,
	output logic      [7:0]          rd_data_b
);
	logic [7:0] mem_q [ident_depth];

	// contents are loaded by software, so no reset on the array
	always_ff @(posedge pclk) begin
		if (wr_en) begin
			mem_q[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_data_a <= 8'h00;
			rd_data_b <= 8'h00;
		end else begin
			rd_data_a <= mem_q[rd_addr_a];
			rd_data_b <= mem_q[rd_addr_b];
		end
	end
endmodule : ident_mem

// file: nvm_seq.sv
// test-port sequencer for lock-bit writes and configuration, signature, calibration reads
//
// Contract
// - a zero data bit programs its lock bit, a one leaves it
// - after commit, poll shows completion, else host waits the full write time
// - after read enable, commands return all bits, fuse high, fuse low or lock
// - signature read: enable, then address and read pairs for bytes 0 to 2
// - calibration read: enable, load address zero, read the single byte
// - port works only with enable fuse programmed and disable bit cleared
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module nvm_seq
	import nvm_seq_pkg::*;
#(
	parameter int write_cycles = write_completion_cycles
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        tck,
	input  wire logic        tms,
	input  wire logic        tdi,
	output logic             tdo,
	output logic             tdo_oe_n
);
	logic [2:0]           tck_sync_q;
	logic [1:0]           tms_sync_q;
	logic [1:0]           tdi_sync_q;
	logic                 tck_rise;
	logic                 tck_fall;
	tap_state_type        tap_q;
	tap_state_type        tap_d;
	logic [ir_width-1:0]  ir_shift_q;
	logic [ir_width-1:0]  ir_q;
	logic [dr_width-1:0]  dr_q;
	logic [dr_width-1:0]  result_q;
	logic                 bypass_q;
	logic                 port_en;
	logic                 prog_sel;
	logic                 upd_cmd;
	logic [7:0]           cmd;
	logic [7:0]           cmd_data;
	mode_type             mode_q;
	logic [7:0]           lock_data_q;
	logic                 busy_q;
	logic [31:0]          busy_cnt_q;
	logic                 commit_done;
	logic                 rd_pend_q;
	logic [ident_aw-1:0]  ident_addr_q;
	logic [7:0]           ident_rd_data;
	logic [7:0]           apb_ident_data;
	logic                 disable_q;
	logic [7:0]           fuse_low_q;
	logic [7:0]           fuse_high_q;
	logic [7:0]           lock_q;
	logic                 apb_access;
	logic                 ident_sel;
	logic                 mapped;
	logic                 ident_wait_q;

	function automatic logic [ident_aw-1:0] ident_idx(input logic [7:0] addr);
		ident_idx = addr[ident_aw+1:2];
	endfunction : ident_idx

	// tck arrives from the host; edges come only from the second and third stages
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// tck rests high, so reset to that level: no false edge at release
			tck_sync_q <= 3'h7;
			tms_sync_q <= 2'h3;
			tdi_sync_q <= 2'h0;
		end else begin
			tck_sync_q <= {tck_sync_q[1:0], tck};
			tms_sync_q <= {tms_sync_q[0], tms};
			tdi_sync_q <= {tdi_sync_q[0], tdi};
		end
	end
	assign tck_rise = tck_sync_q[1] & ~tck_sync_q[2];
	assign tck_fall = ~tck_sync_q[1] & tck_sync_q[2];

	assign port_en = ~fuse_high_q[port_enable_fuse_bit] & ~disable_q;

	always_comb begin
		case (tap_q)
			tap_reset:    tap_d = tms_sync_q[1] ? tap_reset : tap_idle;
			tap_idle:     tap_d = tms_sync_q[1] ? tap_sel_dr : tap_idle;
			tap_sel_dr:   tap_d = tms_sync_q[1] ? tap_sel_ir : tap_cap_dr;
			tap_cap_dr:   tap_d = tms_sync_q[1] ? tap_exit1_dr : tap_shift_dr;
			tap_shift_dr: tap_d = tms_sync_q[1] ? tap_exit1_dr : tap_shift_dr;
			tap_exit1_dr: tap_d = tms_sync_q[1] ? tap_upd_dr : tap_pause_dr;
			tap_pause_dr: tap_d = tms_sync_q[1] ? tap_exit2_dr : tap_pause_dr;
			tap_exit2_dr: tap_d = tms_sync_q[1] ? tap_upd_dr : tap_shift_dr;
			tap_upd_dr:   tap_d = tms_sync_q[1] ? tap_sel_dr : tap_idle;
			tap_sel_ir:   tap_d = tms_sync_q[1] ? tap_reset : tap_cap_ir;
			tap_cap_ir:   tap_d = tms_sync_q[1] ? tap_exit1_ir : tap_shift_ir;
			tap_shift_ir: tap_d = tms_sync_q[1] ? tap_exit1_ir : tap_shift_ir;
			tap_exit1_ir: tap_d = tms_sync_q[1] ? tap_upd_ir : tap_pause_ir;
			tap_pause_ir: tap_d = tms_sync_q[1] ? tap_exit2_ir : tap_pause_ir;
			tap_exit2_ir: tap_d = tms_sync_q[1] ? tap_upd_ir : tap_shift_ir;
			tap_upd_ir:   tap_d = tms_sync_q[1] ? tap_sel_dr : tap_idle;
			default:      tap_d = tap_reset;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tap_q <= tap_reset;
		end else if (!port_en) begin
			tap_q <= tap_reset;
		end else if (tck_rise) begin
			tap_q <= tap_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ir_shift_q <= '0;
			ir_q       <= bypass_code;
		end else if (tap_q == tap_reset) begin
			ir_q <= bypass_code;
		end else if (tck_rise) begin
			case (tap_q)
				tap_cap_ir:   ir_shift_q <= ir_capture;
				tap_shift_ir: ir_shift_q <= {tdi_sync_q[1], ir_shift_q[ir_width-1:1]};
				tap_upd_ir:   ir_q <= ir_shift_q;
				default:      ir_q <= ir_q;
			endcase
		end
	end

	// only this instruction reaches the sequencer
	assign prog_sel = (ir_q == prog_ir_code);

	// one word per command, read result captured for the next shift
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dr_q     <= '0;
			bypass_q <= 1'b0;
		end else if (tck_rise) begin
			case (tap_q)
				tap_cap_dr: begin
					dr_q     <= result_q;
					bypass_q <= 1'b0;
				end
				tap_shift_dr: begin
					dr_q     <= {tdi_sync_q[1], dr_q[dr_width-1:1]};
					bypass_q <= tdi_sync_q[1];
				end
				default: bypass_q <= bypass_q;
			endcase
		end
	end

	assign upd_cmd  = tck_rise & (tap_q == tap_upd_dr) & prog_sel;
	assign cmd      = dr_q[dr_width-1:dr_width-8];
	assign cmd_data = dr_q[7:0];

	// tdo changes on the falling test clock and drives only while shifting
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tdo      <= 1'b0;
			tdo_oe_n <= 1'b1;
		end else if (!port_en) begin
			tdo_oe_n <= 1'b1;
		end else if (tck_fall) begin
			tdo_oe_n <= ~((tap_q == tap_shift_dr) | (tap_q == tap_shift_ir));
			if (tap_q == tap_shift_ir) begin
				tdo <= ir_shift_q[0];
			end else begin
				tdo <= prog_sel ? dr_q[0] : bypass_q;
			end
		end
	end

	// enable commands pick the mode that later commands need
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q      <= mode_none;
			lock_data_q <= lock_reset;
		end else if (tap_q == tap_reset) begin
			mode_q <= mode_none;
		end else if (upd_cmd) begin
			case (cmd)
				cmd_lock_wr_en: mode_q <= mode_lock_wr;
				cmd_cfg_rd_en:  mode_q <= mode_cfg_rd;
				cmd_sig_en:     mode_q <= mode_sig_rd;
				cmd_cal_en:     mode_q <= mode_cal_rd;
				cmd_lock_load: begin
					if (mode_q == mode_lock_wr) begin
						lock_data_q <= cmd_data;
					end
				end
				default: mode_q <= mode_q;
			endcase
		end
	end

	// write timer for the committed lock write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_q     <= 1'b0;
			busy_cnt_q <= '0;
		end else if (busy_q) begin
			busy_cnt_q <= busy_cnt_q - 32'd1;
			busy_q     <= (busy_cnt_q != 32'd1);
		end else if (upd_cmd && cmd == cmd_lock_commit && mode_q == mode_lock_wr) begin
			busy_q     <= 1'b1;
			busy_cnt_q <= 32'(write_cycles);
		end
	end
	assign commit_done = busy_q & (busy_cnt_q == 32'd1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ident_addr_q <= '0;
			rd_pend_q    <= 1'b0;
		end else begin
			rd_pend_q <= upd_cmd & (((cmd == cmd_sig_rd) & (mode_q == mode_sig_rd)) |
				((cmd == cmd_cal_rd) & (mode_q == mode_cal_rd)));
			if (upd_cmd && cmd == cmd_sig_addr && mode_q == mode_sig_rd) begin
				ident_addr_q <= cmd_data[ident_aw-1:0];
			end else if (upd_cmd && cmd == cmd_cal_addr && mode_q == mode_cal_rd) begin
				ident_addr_q <= cal_index;
			end
		end
	end

	// read results, held until the next read command replaces them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_q <= '0;
		end else if (rd_pend_q) begin
			// identity byte from the registered store
			result_q <= {16'h0000, ident_rd_data};
		end else if (upd_cmd) begin
			case (cmd)
				// poll answers done in bit 0
				cmd_lock_poll:  result_q <= {23'h000000, ~busy_q};
				cmd_all_rd:     result_q <= (mode_q == mode_cfg_rd) ?
					{fuse_high_q, fuse_low_q, lock_q} : result_q;
				cmd_fuse_high:  result_q <= (mode_q == mode_cfg_rd) ?
					{16'h0000, fuse_high_q} : result_q;
				cmd_fuse_low:   result_q <= (mode_q == mode_cfg_rd) ?
					{16'h0000, fuse_low_q} : result_q;
				cmd_lock_rd:    result_q <= (mode_q == mode_cfg_rd) ?
					{16'h0000, lock_q} : result_q;
				default:        result_q <= result_q;
			endcase
		end
	end

	// apb slave: identity reads take one extra cycle for the registered store
	assign apb_access = psel & penable;
	assign ident_sel  = (paddr >= ident_base_offset) & (paddr <= ident_last_offset) &
		(paddr[1:0] == 2'b00);
	assign mapped     = ident_sel | (paddr == ctrl_offset) | (paddr == status_offset) |
		(paddr == fuse_offset);
	assign pready     = ~(apb_access & ident_sel & ~pwrite & ~ident_wait_q);
	assign pslverr    = apb_access & ~mapped;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ident_wait_q <= 1'b0;
		end else begin
			ident_wait_q <= apb_access & ident_sel & ~pwrite & ~ident_wait_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			disable_q   <= 1'b0;
			fuse_low_q  <= fuse_low_reset;
			fuse_high_q <= fuse_high_reset;
			lock_q      <= lock_reset;
		end else begin
			if (apb_access && pwrite && paddr == ctrl_offset) begin
				disable_q <= pwdata[disable_ctrl_bit];
			end
			if (apb_access && pwrite && paddr == fuse_offset) begin
				fuse_low_q  <= pwdata[7:0];
				fuse_high_q <= pwdata[15:8];
			end
			// zeros program, ones keep; a commit overrides a same-cycle bus write
			if (commit_done) begin
				lock_q <= lock_q & lock_data_q;
			end else if (apb_access && pwrite && paddr == fuse_offset) begin
				lock_q <= pwdata[23:16];
			end
		end
	end

	// loaded in the setup cycle and again in the identity wait cycle, so the
	// read data already stands at the edge where pready is sampled high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel && !pwrite && !(apb_access && pready)) begin
			if (ident_sel) begin
				prdata <= {24'h000000, apb_ident_data};
			end else if (paddr == ctrl_offset) begin
				prdata <= {31'h00000000, disable_q};
			end else if (paddr == status_offset) begin
				prdata <= {26'h0000000, ir_q == prog_ir_code, tap_q == tap_reset,
					mode_q != mode_none, port_en, busy_q, 1'b0};
			end else if (paddr == fuse_offset) begin
				prdata <= {8'h00, lock_q, fuse_high_q, fuse_low_q};
			end else begin
				prdata <= 32'h00000000;
			end
		end
	end

	ident_mem u_ident_mem (
		.pclk      (pclk),
		.presetn   (presetn),
		.wr_en     (apb_access & pwrite & ident_sel),
		.wr_addr   (ident_idx(paddr)),
		.wr_data   (pwdata[7:0]),
		.rd_addr_a (ident_idx(paddr)),
		.rd_data_a (apb_ident_data),
		.rd_addr_b (ident_addr_q),
		.rd_data_b (ident_rd_data)
	);
endmodule : nvm_seq

// file: nvm_seq_assertions.sv
// concurrent checks on the sequencer's bus and test-port pins
`timescale 1ns/1ps
module nvm_seq_checker
	import nvm_seq_pkg::*;
#(
	parameter int write_cycles = write_completion_cycles
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        tdo_oe_n
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic acc;
	logic off;
	logic dis_q;
	logic fz_q;
	assign acc = psel && penable;
	assign off = dis_q || fz_q;
	// port controls tracked from bus writes; a lock commit never touches these bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dis_q <= 1'b0;
			fz_q  <= 1'b0;
		end else if (acc && pwrite) begin
			if (paddr == ctrl_offset) dis_q <= pwdata[disable_ctrl_bit];
			if (paddr == fuse_offset) fz_q <= pwdata[8 + port_enable_fuse_bit];
		end
	end
	chk_err_phase: assert property (pslverr |-> acc)
		else $error("slave error outside access phase");
	chk_err_hole: assert property (acc && paddr == 8'h0C |-> pslverr && pready)
		else $error("unmapped access not refused");
	chk_ok_fuse: assert property (acc && paddr == fuse_offset |-> !pslverr && pready)
		else $error("fuse access refused or stalled");
	chk_hole_zero: assert property (acc && !pwrite && paddr == 8'h0C |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	chk_wait_ident: assert property (
		!pready |-> acc && !pwrite && (paddr & 8'hF3) == 8'h10)
		else $error("wait state outside identity read");
	chk_wait_once: assert property (!pready |=> pready)
		else $error("wait state longer than one cycle");
	chk_sig_stall: assert property (
		psel && !penable && !pwrite && paddr == 8'h10 ##1 acc |-> !pready)
		else $error("identity read without wait state");
	chk_rdata_hold: assert property (!psel ##1 !psel |-> $stable(prdata))
		else $error("read data moved while idle");
	chk_port_off: assert property (off && $past(off, 4) |-> tdo_oe_n)
		else $error("test data driven while port disabled");
endmodule : nvm_seq_checker

bind nvm_seq nvm_seq_checker #(.write_cycles(write_cycles)) nvm_seq_checker_i (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.tdo_oe_n
);

// file: jtag_host.sv
// behavioural test-port host: walks the tap and shifts words
`timescale 1ns/1ps
module jtag_host (
	input  wire logic pclk,
	input  wire logic tdo,
	output logic      tck,
	output logic      tms,
	output logic      tdi
);
	// tck rests high between frames
	initial begin
		tck = 1'b1;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// one bit per 200 ns tck period
	task automatic step(input logic m, input logic d, output logic o);
		@(posedge pclk);
		tck <= 1'b0;
		tms <= m;
		tdi <= d;
		repeat (4) @(posedge pclk);
		tck <= 1'b1;
		repeat (3) @(posedge pclk);
		o = tdo;
	endtask : step
	task automatic reset_tap;
		logic o;
		repeat (5) step(1'b1, 1'b0, o);
		step(1'b0, 1'b1, o);
	endtask : reset_tap
	// from idle through one ir or dr scan back to idle; tdi toggles once released
	task automatic scan(input logic ir, input int n, input logic [23:0] din,
		output logic [23:0] dout);
		logic o;
		dout = '0;
		step(1'b1, din[0], o);
		if (ir) step(1'b1, din[0], o);
		step(1'b0, din[0], o);
		step(1'b0, din[0], o);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], o);
			dout[i] = o;
		end
		step(1'b1, ~din[n-1], o);
		step(1'b0, din[n-1], o);
	endtask : scan
endmodule : jtag_host

// file: tb.sv
// self-checking bench for the test-port configuration sequencer
`timescale 1ns/1ps
module tb;
	import nvm_seq_pkg::*;
	localparam int wc = 400;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, msk;
	logic        pready, pslverr, tck, tms, tdi, tdo, tdo_oe_n;
	logic        tdo_pin;
	logic [23:0] r;
	logic [7:0]  fl, fh, lk, d;
	logic [7:0]  sig [4];
	logic [31:0] exp_q [$];
	logic [31:0] msk_q [$];
	int          bad_count = 0;
	int          num_checks = 0;

	always #12.5 pclk = ~pclk;

	nvm_seq #(.write_cycles(wc)) nvm_seq_i (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .tck, .tms, .tdi, .tdo, .tdo_oe_n);
	// a released tdo shows the inverse of its last value, so a late enable is caught
	assign tdo_pin = tdo_oe_n ? ~tdo : tdo;
	jtag_host jtag_host_i (.pclk, .tdo(tdo_pin), .tck, .tms, .tdi);

	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : finish_test
	task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, exp, seen);
		end
	endtask : check
	// reads leave their masked expectation for the monitor
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v,
		input logic [31:0] m);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= w ? v : $urandom();
		if (!w) exp_q.push_back(v & m);
		if (!w) msk_q.push_back(m);
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			bad_count++;
			finish_test();
		end
	endtask : apb
	task automatic cmd(input logic [7:0] c, input logic [7:0] dt);
		jtag_host_i.scan(1'b0, dr_width, {c, 8'h00, dt}, r);
	endtask : cmd

	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
			msk = msk_q.pop_front();
			check("prdata", prdata & msk, exp_q.pop_front());
		end
	end

	initial begin
		void'($urandom(32'h72285e5c));
		fl = 8'($urandom());
		fh = 8'($urandom()) & 8'hBF;
		lk = 8'($urandom());
		d = 8'($urandom());
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, fuse_offset, 32'h00FFBFFF, '1);
		apb(1'b0, status_offset, 32'h4, 32'h4);
		apb(1'b0, 8'h0C, 32'h0, '1);
		apb(1'b1, fuse_offset, {8'h00, lk, fh, fl}, '0);
		apb(1'b0, fuse_offset, {8'h00, lk, fh, fl}, '1);
		for (int i = 0; i < ident_depth; i++) begin
			sig[i] = 8'($urandom());
			apb(1'b1, ident_base_offset + 8'(4 * i), {24'h0, sig[i]}, '0);
			apb(1'b0, ident_base_offset + 8'(4 * i), {24'h0, sig[i]}, '1);
		end
		$display("test registers done");
		jtag_host_i.reset_tap();
		jtag_host_i.scan(1'b1, ir_width, {20'h0, prog_ir_code}, r);
		check("ir capture", 32'(r[3:0]), 32'(ir_capture));
		apb(1'b0, status_offset, 32'h20, 32'h38);
		cmd(cmd_cfg_rd_en, 8'h00);
		cmd(cmd_all_rd, 8'h00);
		cmd(cmd_fuse_high, 8'h00);
		check("all bits", 32'(r), 32'({fh, fl, lk}));
		cmd(cmd_fuse_low, 8'h00);
		check("fuse high", 32'(r[7:0]), 32'(fh));
		cmd(cmd_lock_rd, 8'h00);
		check("fuse low", 32'(r[7:0]), 32'(fl));
		cmd(cmd_sig_en, 8'h00);
		check("lock", 32'(r[7:0]), 32'(lk));
		for (int a = 0; a < 3; a++) begin
			cmd(cmd_sig_addr, 8'(a));
			cmd(cmd_sig_rd, 8'h00);
			cmd(cmd_sig_addr, 8'(a));
			check("signature", 32'(r[7:0]), 32'(sig[a]));
		end
		// a read outside its mode must leave the result alone
		cmd(cmd_fuse_high, 8'h00);
		cmd(cmd_cal_en, 8'h00);
		check("refused read", 32'(r[7:0]), 32'(sig[2]));
		cmd(cmd_cal_addr, 8'($urandom()));
		cmd(cmd_cal_rd, 8'h00);
		cmd(cmd_lock_wr_en, 8'h00);
		check("calibration", 32'(r[7:0]), 32'(sig[cal_index]));
		cmd(cmd_lock_load, d);
		cmd(cmd_lock_commit, 8'h00);
		apb(1'b0, status_offset, 32'hA, 32'hA);
		// first poll lands inside the write time, the second after it
		cmd(cmd_lock_poll, 8'h00);
		cmd(cmd_lock_poll, 8'h00);
		check("poll busy", 32'(r[0]), 32'h0);
		cmd(cmd_lock_poll, 8'h00);
		check("poll", 32'(r[0]), 32'h1);
		apb(1'b0, status_offset, 32'h4, 32'h6);
		apb(1'b0, fuse_offset, {8'h00, lk & d, fh, fl}, '1);
		$display("test programming commands done");
		apb(1'b1, ctrl_offset, 32'h1, '0);
		apb(1'b0, ctrl_offset, 32'h1, '1);
		jtag_host_i.scan(1'b1, ir_width, {20'h0, prog_ir_code}, r);
		apb(1'b0, status_offset, 32'h10, 32'h14);
		apb(1'b1, ctrl_offset, 32'h0, '0);
		apb(1'b1, fuse_offset, {8'h00, lk & d, fh | 8'h40, fl}, '0);
		apb(1'b0, status_offset, 32'h10, 32'h14);
		apb(1'b1, fuse_offset, {8'h00, lk & d, fh, fl}, '0);
		apb(1'b0, status_offset, 32'h4, 32'h4);
		$display("test port control done");
		finish_test();
	end
endmodule : tb
